// *** core/dmog_pkg.sv ***
// Package: constants for the drive monitor output generator
package dmog_pkg;
	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [3:0] A_DSEL = 4'h0; // Digital pin source
	localparam logic [3:0] A_DGAIN = 4'h1; // Digital pin gain
	localparam logic [3:0] A_VSEL = 4'h2; // Voltage channel source
	localparam logic [3:0] A_VGAIN = 4'h3; // Voltage channel gain
	localparam logic [3:0] A_VOFS = 4'h4; // Voltage offset, 0.1 V
	localparam logic [3:0] A_CSEL = 4'h5; // Current channel source
	localparam logic [3:0] A_CGAIN = 4'h6; // Current channel gain
	localparam logic [3:0] A_COFS = 4'h7; // Current offset, 0.1 mA
	localparam logic [3:0] A_MAXF = 4'h8; // Max frequency, 0.1 Hz
	localparam logic [3:0] A_CTRL = 4'h9; // Calibration control
	localparam logic [3:0] A_FSRC = 4'ha; // Frequency source
	localparam logic [3:0] A_STAT = 4'hb; // Status, read only
	localparam logic [3:0] A_VCODE = 4'hc; // Voltage code, read only
	localparam logic [3:0] A_CCODE = 4'hd; // Current code, read only
	localparam logic [3:0] A_DUTY = 4'he; // PWM duty, read only
	// ---------------------------------------------------------------
	// Reset values and limits
	// ---------------------------------------------------------------
	localparam logic [2:0] RST_SEL = 3'h0;
	localparam logic [7:0] RST_DGAIN = 8'hff;
	localparam logic [7:0] RST_VGAIN = 8'hb4; // 180
	localparam logic [7:0] RST_CGAIN = 8'h50; // 80
	localparam logic [11:0] RST_MAXF = 12'h258; // 60.0 Hz
	localparam logic [15:0] VOFS_MAX = 16'h0064; // 10.0 V
	localparam logic [15:0] COFS_MAX = 16'h00c8; // 20.0 mA
	localparam logic [15:0] MAXF_MAX = 16'h0fa0; // 400.0 Hz
	localparam logic [7:0] GAIN_MAX = 8'hff;
	localparam int CTRL_CAL = 0; // Force pin high bit
	// ---------------------------------------------------------------
	// Source codes, control methods, spans
	// ---------------------------------------------------------------
	localparam logic [2:0] SEL_FM = 3'h3;
	localparam logic [2:0] VEC_FIRST = 3'h3; // Sensorless vector
	localparam logic [2:0] VEC_LAST = 3'h5; // Encoder vector
	localparam logic [1:0] FSRC_ANALOG = 2'h1;
	localparam logic [11:0] FS_PCT200 = 12'h7d0; // 200.0 %
	localparam logic [11:0] FS_PCT100 = 12'h3e8; // 100.0 %
	localparam logic [10:0] SPAN_PWM = 11'h100; // Duty steps
	localparam logic [10:0] SPAN_V = 11'h3e8; // 10.00 V
	localparam logic [10:0] SPAN_I = 11'h640; // 16.00 mA
	localparam logic [10:0] BASE_I = 11'h190; // 4.00 mA
	localparam logic [11:0] CODE_I_MAX = 12'h7d0; // 20.00 mA
	localparam logic [11:0] OFS_SCALE = 12'h00a;
	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam longint CLK_HZ = 40000000;
	localparam int SAMPLE_US = 100;
	localparam int SAMPLE_CYCLES = int'(SAMPLE_US * CLK_HZ / 1000000);
	localparam logic [7:0] FM_K = 8'(64'h100000000 / CLK_HZ);
	// Digital pin drive modes
	typedef enum logic [1:0] {MODE_PWM, MODE_FM, MODE_CAL} dmog_mode_e;
endpackage : dmog_pkg

// *** core/dmog_top.sv ***
// Module: drive monitor output generator, pin and two analog codes
//
// Function
// - Digital pin source from eight codes
// - Full scale per quantity, max frequency for the frequencies
// - PWM value is high time over period
// - Eight-bit gain scales PWM duty
// - Calibration drives pin continuously high
// - FM pulse rate ten times frequency
// - FM code ignores gain, digital generation
// - Voltage 0-10 V, current 4-20 mA
// - Analog selects refuse FM code
// - Analog channels select independently
// - Torque valid only under vector control
// - Voltage gain default 180, offset 0 to 10 V
// - Current gain default 80, offset 0 to 20 mA
// - Analog frequency source only when 01
`timescale 1ns/1ps
module dmog_top #(
	parameter int PWM_DIV = 16, // Clocks per duty step
	parameter int SAMPLE_CYCLES = dmog_pkg::SAMPLE_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input wire logic [11:0] out_freq, // 0.1 Hz units
	input wire logic [11:0] out_current, // 0.1 % units
	input wire logic [11:0] out_torque,
	input wire logic [11:0] out_voltage,
	input wire logic [11:0] in_power,
	input wire logic [11:0] thermal_load,
	input wire logic [11:0] ramp_frequency,
	input wire logic [2:0] control_method,
	output logic digital_monitor_pin,
	output logic [10:0] voltage_monitor_channel, // 0.01 V
	output logic [10:0] current_loop_monitor_channel, // 0.01 mA
	output logic analog_freq_source_en
);
	// ---------------------------------------------------------------
	// Register decode
	// ---------------------------------------------------------------
	logic [2:0] dsel_reg, vsel_reg, csel_reg; // Source selects
	logic [7:0] dgain_reg, vgain_reg, cgain_reg; // Gains
	logic [7:0] vofs_reg, cofs_reg; // Offsets, 0.1 units
	logic [11:0] maxf_reg; // Max frequency
	logic cal_reg; // Calibration force
	logic [1:0] fsrc_reg; // Frequency source
	wire sel_ok = reg_wdata[2:0] != dmog_pkg::SEL_FM;
	wire wr_dsel = reg_wr && reg_addr == dmog_pkg::A_DSEL;
	wire wr_dgain = reg_wr && reg_addr == dmog_pkg::A_DGAIN;
	wire wr_vsel = reg_wr && reg_addr == dmog_pkg::A_VSEL && sel_ok;
	wire wr_vgain = reg_wr && reg_addr == dmog_pkg::A_VGAIN;
	wire wr_vofs = reg_wr && reg_addr == dmog_pkg::A_VOFS;
	wire wr_csel = reg_wr && reg_addr == dmog_pkg::A_CSEL && sel_ok;
	wire wr_cgain = reg_wr && reg_addr == dmog_pkg::A_CGAIN;
	wire wr_cofs = reg_wr && reg_addr == dmog_pkg::A_COFS;
	wire wr_maxf = reg_wr && reg_addr == dmog_pkg::A_MAXF;
	wire wr_ctrl = reg_wr && reg_addr == dmog_pkg::A_CTRL;
	wire wr_fsrc = reg_wr && reg_addr == dmog_pkg::A_FSRC;
	// Offsets and max frequency saturate at their range tops
	wire [7:0] vofs_next = (reg_wdata > dmog_pkg::VOFS_MAX) ?
		dmog_pkg::VOFS_MAX[7:0] : reg_wdata[7:0];
	wire [7:0] cofs_next = (reg_wdata > dmog_pkg::COFS_MAX) ?
		dmog_pkg::COFS_MAX[7:0] : reg_wdata[7:0];
	wire [11:0] maxf_next = (reg_wdata > dmog_pkg::MAXF_MAX) ?
		dmog_pkg::MAXF_MAX[11:0] : reg_wdata[11:0];

	// ---------------------------------------------------------------
	// Setting registers
	// ---------------------------------------------------------------
	// Software writes; reset restores the defaults
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			dsel_reg <= dmog_pkg::RST_SEL;
			vsel_reg <= dmog_pkg::RST_SEL;
			csel_reg <= dmog_pkg::RST_SEL;
			dgain_reg <= dmog_pkg::RST_DGAIN;
			vgain_reg <= dmog_pkg::RST_VGAIN;
			cgain_reg <= dmog_pkg::RST_CGAIN;
			vofs_reg <= 8'h00;
			cofs_reg <= 8'h00;
			maxf_reg <= dmog_pkg::RST_MAXF;
			cal_reg <= 1'b0;
			fsrc_reg <= 2'h0;
		end else begin
			if (wr_dsel) dsel_reg <= reg_wdata[2:0];
			if (wr_dgain) dgain_reg <= reg_wdata[7:0];
			if (wr_vsel) vsel_reg <= reg_wdata[2:0];
			if (wr_csel) csel_reg <= reg_wdata[2:0];
			if (wr_vgain) vgain_reg <= reg_wdata[7:0];
			if (wr_cgain) cgain_reg <= reg_wdata[7:0];
			if (wr_vofs) vofs_reg <= vofs_next;
			if (wr_cofs) cofs_reg <= cofs_next;
			if (wr_maxf) maxf_reg <= maxf_next;
			if (wr_ctrl) cal_reg <= reg_wdata[dmog_pkg::CTRL_CAL];
			if (wr_fsrc) fsrc_reg <= reg_wdata[1:0];
		end
	end

	// ---------------------------------------------------------------
	// Quantity table
	// ---------------------------------------------------------------
	logic [11:0] qval [0:7]; // Monitored values
	logic [11:0] qfs [0:7]; // Their full scales
	// Torque shows zero outside vector control
	wire torque_ok = control_method >= dmog_pkg::VEC_FIRST &&
		control_method <= dmog_pkg::VEC_LAST;
	assign qval[0] = out_freq;
	assign qval[1] = out_current;
	assign qval[2] = torque_ok ? out_torque : 12'h000;
	assign qval[3] = out_freq;
	assign qval[4] = out_voltage;
	assign qval[5] = in_power;
	assign qval[6] = thermal_load;
	assign qval[7] = ramp_frequency;
	assign qfs[0] = maxf_reg;
	assign qfs[1] = dmog_pkg::FS_PCT200;
	assign qfs[2] = dmog_pkg::FS_PCT200;
	assign qfs[3] = maxf_reg;
	assign qfs[4] = dmog_pkg::FS_PCT100;
	assign qfs[5] = dmog_pkg::FS_PCT200;
	assign qfs[6] = dmog_pkg::FS_PCT100;
	assign qfs[7] = maxf_reg;

	// ---------------------------------------------------------------
	// Per-channel scaling: pin, voltage, current
	// ---------------------------------------------------------------
	logic [2:0] ch_sel [0:2];
	logic [7:0] ch_gain [0:2];
	logic [10:0] ch_span [0:2];
	logic [10:0] ch_scaled [0:2]; // Value/fs * gain/255 * span
	assign ch_sel[0] = dsel_reg;
	assign ch_sel[1] = vsel_reg;
	assign ch_sel[2] = csel_reg;
	assign ch_gain[0] = dgain_reg;
	assign ch_gain[1] = vgain_reg;
	assign ch_gain[2] = cgain_reg;
	assign ch_span[0] = dmog_pkg::SPAN_PWM;
	assign ch_span[1] = dmog_pkg::SPAN_V;
	assign ch_span[2] = dmog_pkg::SPAN_I;
	genvar g;
	for (g = 0; g < 3; g++) begin : g_ch
		wire [31:0] num = 32'(qval[ch_sel[g]]) * 32'(ch_gain[g]) *
			32'(ch_span[g]);
		wire [31:0] den = 32'(qfs[ch_sel[g]]) * 32'(dmog_pkg::GAIN_MAX);
		// Zero full scale counts as saturated
		wire [31:0] quo = (den == 32'h0) ? 32'(ch_span[g]) : num / den;
		assign ch_scaled[g] = (quo > 32'(ch_span[g])) ?
			ch_span[g] : quo[10:0];
	end

	// ---------------------------------------------------------------
	// Digital pin: PWM, FM, calibration
	// ---------------------------------------------------------------
	logic [7:0] pre_reg; // Duty step prescaler
	logic [7:0] cnt_reg; // Position in PWM period
	logic [8:0] duty_reg; // High steps this period
	logic [31:0] acc_reg; // FM phase accumulator
	dmog_pkg::dmog_mode_e mode_w;
	wire step = pre_reg == 8'(PWM_DIV - 1);
	wire period_end = step && cnt_reg == 8'hff;
	// Calibration wins, then FM, else PWM
	assign mode_w = cal_reg ? dmog_pkg::MODE_CAL :
		(dsel_reg == dmog_pkg::SEL_FM) ? dmog_pkg::MODE_FM :
		dmog_pkg::MODE_PWM;
	// FM rate in Hz equals frequency in 0.1 Hz, capped at max
	wire [11:0] fm_freq = (out_freq > maxf_reg) ? maxf_reg : out_freq;
	wire [31:0] fm_inc = 32'(fm_freq) * 32'(dmog_pkg::FM_K);
	wire [31:0] acc_next = (mode_w == dmog_pkg::MODE_FM) ?
		acc_reg + fm_inc : 32'h0;
	logic pin_next;
	always_comb begin
		case (mode_w)
			dmog_pkg::MODE_CAL: pin_next = 1'b1;
			dmog_pkg::MODE_FM: pin_next = acc_reg[31];
			dmog_pkg::MODE_PWM: pin_next = {1'b0, cnt_reg} < duty_reg;
			default: pin_next = 1'b0;
		endcase
	end
	// Duty loads only at period end, no mid-period glitch
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pre_reg <= 8'h00;
			cnt_reg <= 8'h00;
			duty_reg <= 9'h000;
			acc_reg <= 32'h0;
			digital_monitor_pin <= 1'b0;
		end else begin
			pre_reg <= step ? 8'h00 : pre_reg + 8'h01;
			if (step) cnt_reg <= cnt_reg + 8'h01;
			if (period_end) duty_reg <= ch_scaled[0][8:0];
			acc_reg <= acc_next;
			digital_monitor_pin <= pin_next;
		end
	end

	// ---------------------------------------------------------------
	// Analog channels, updated once per sample period
	// ---------------------------------------------------------------
	logic [12:0] smp_reg; // Sample period counter
	wire tick = smp_reg == 13'(SAMPLE_CYCLES - 1);
	wire [11:0] v_sum = {1'b0, ch_scaled[1]} +
		12'(vofs_reg) * dmog_pkg::OFS_SCALE;
	wire [11:0] c_sum = {1'b0, dmog_pkg::BASE_I} + {1'b0, ch_scaled[2]} +
		12'(cofs_reg) * dmog_pkg::OFS_SCALE;
	wire [10:0] v_code = (v_sum > {1'b0, dmog_pkg::SPAN_V}) ?
		dmog_pkg::SPAN_V : v_sum[10:0];
	wire [10:0] c_code = (c_sum > dmog_pkg::CODE_I_MAX) ?
		dmog_pkg::CODE_I_MAX[10:0] : c_sum[10:0];
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			smp_reg <= 13'h0000;
			voltage_monitor_channel <= 11'h000;
			current_loop_monitor_channel <= dmog_pkg::BASE_I;
			analog_freq_source_en <= 1'b0;
		end else begin
			smp_reg <= tick ? 13'h0000 : smp_reg + 13'h0001;
			if (tick) voltage_monitor_channel <= v_code;
			if (tick) current_loop_monitor_channel <= c_code;
			analog_freq_source_en <=
				fsrc_reg == dmog_pkg::FSRC_ANALOG;
		end
	end

	// ---------------------------------------------------------------
	// Read path: data in the cycle after the strobe only
	// ---------------------------------------------------------------
	wire [15:0] stat = {12'h000, fsrc_reg == dmog_pkg::FSRC_ANALOG,
		mode_w == dmog_pkg::MODE_FM, torque_ok, cal_reg};
	wire [15:0] rd_mux =
		(reg_addr == dmog_pkg::A_DSEL) ? {13'h0, dsel_reg} :
		(reg_addr == dmog_pkg::A_DGAIN) ? {8'h00, dgain_reg} :
		(reg_addr == dmog_pkg::A_VSEL) ? {13'h0, vsel_reg} :
		(reg_addr == dmog_pkg::A_VGAIN) ? {8'h00, vgain_reg} :
		(reg_addr == dmog_pkg::A_VOFS) ? {8'h00, vofs_reg} :
		(reg_addr == dmog_pkg::A_CSEL) ? {13'h0, csel_reg} :
		(reg_addr == dmog_pkg::A_CGAIN) ? {8'h00, cgain_reg} :
		(reg_addr == dmog_pkg::A_COFS) ? {8'h00, cofs_reg} :
		(reg_addr == dmog_pkg::A_MAXF) ? {4'h0, maxf_reg} :
		(reg_addr == dmog_pkg::A_CTRL) ? {15'h0, cal_reg} :
		(reg_addr == dmog_pkg::A_FSRC) ? {14'h0, fsrc_reg} :
		(reg_addr == dmog_pkg::A_STAT) ? stat :
		(reg_addr == dmog_pkg::A_VCODE) ? {5'h00, voltage_monitor_channel} :
		(reg_addr == dmog_pkg::A_CCODE) ?
		{5'h00, current_loop_monitor_channel} :
		(reg_addr == dmog_pkg::A_DUTY) ? {7'h00, duty_reg} : 16'h0000;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) reg_rdata <= 16'h0000;
		else reg_rdata <= reg_rd ? rd_mux : 16'h0000;
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_cal_held;
		cal_reg ##1 cal_reg;
	endsequence
	sequence s_pwm_cycle;
		mode_w == dmog_pkg::MODE_PWM;
	endsequence
	a_select_code: assert property (
		wr_dsel |=> dsel_reg == $past(reg_wdata[2:0]))
		else $error("digital select not stored");
	a_cal_pin_high: assert property (
		s_cal_held |-> digital_monitor_pin)
		else $error("calibration pin not high");
	a_pwm_duty_pin: assert property (
		s_pwm_cycle |=> digital_monitor_pin ==
		({1'b0, $past(cnt_reg)} < $past(duty_reg)))
		else $error("pwm pin mismatch");
	a_duty_full_scale: assert property (
		duty_reg <= 9'(dmog_pkg::SPAN_PWM))
		else $error("duty above period");
	a_fm_phase_step: assert property (
		mode_w == dmog_pkg::MODE_FM && !cal_reg ##1
		mode_w == dmog_pkg::MODE_FM |->
		acc_reg == $past(acc_reg) + $past(fm_inc))
		else $error("fm phase step wrong");
	a_fm_pin_follows: assert property (
		mode_w == dmog_pkg::MODE_FM |=>
		digital_monitor_pin == $past(acc_reg[31]))
		else $error("fm pin not from accumulator");
	a_no_fm_analog: assert property (
		vsel_reg != dmog_pkg::SEL_FM && csel_reg != dmog_pkg::SEL_FM)
		else $error("analog channel holds fm code");
	a_torque_gate: assert property (
		!torque_ok |-> qval[2] == 12'h000)
		else $error("torque shown outside vector");
	a_volt_span: assert property (
		voltage_monitor_channel <= dmog_pkg::SPAN_V)
		else $error("voltage code above span");
	a_cur_span: assert property (
		current_loop_monitor_channel >= dmog_pkg::BASE_I &&
		current_loop_monitor_channel <= dmog_pkg::CODE_I_MAX[10:0])
		else $error("current code out of span");
	a_sample_update: assert property (
		!$stable(voltage_monitor_channel) |-> $past(tick))
		else $error("voltage code moved off tick");
	a_freq_source: assert property (
		wr_fsrc ##1 !wr_fsrc |=> analog_freq_source_en ==
		($past(reg_wdata[1:0], 2) == dmog_pkg::FSRC_ANALOG))
		else $error("frequency source flag wrong");
	a_vgain_reset: assert property (
		$fell(rst) |-> vgain_reg == dmog_pkg::RST_VGAIN)
		else $error("voltage gain default wrong");
endmodule : dmog_top

// *** sim/dmog_bench.sv ***
// Self-checking bench for the drive monitor output generator
`timescale 1ns/1ps
module dmog_bench;
	localparam int SC = 8; // Short analog sample period
	localparam int LIMIT = 95000; // Cycle ceiling
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic [11:0] out_freq = 12'h12c; // Half of 60.0 Hz
	logic [11:0] out_current = 12'h5dc;
	logic [11:0] out_torque = 12'h7d0;
	logic [11:0] out_voltage = 12'h1f4;
	logic [11:0] in_power = 12'h190;
	logic [11:0] thermal_load = 12'h0fa;
	logic [11:0] ramp_frequency = 12'h258;
	logic [2:0] control_method = 3'h0;
	logic digital_monitor_pin;
	logic [10:0] voltage_monitor_channel;
	logic [10:0] current_loop_monitor_channel;
	logic analog_freq_source_en;
	logic meter_clear = 1'b0;
	logic [31:0] high_cnt;
	logic [31:0] edge_cnt;
	int error_cnt = 0;
	int comparisons = 0;
	int cyc = 0;
	int codes[7] = '{0, 1, 2, 4, 5, 6, 7}; // Analog-legal sources
	// Clock, 25 ns period
	initial begin
		forever #12.5 core_clk = ~core_clk;
	end
	dmog_top #(.PWM_DIV(1), .SAMPLE_CYCLES(SC)) dut (
		.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .out_freq(out_freq),
		.out_current(out_current), .out_torque(out_torque),
		.out_voltage(out_voltage), .in_power(in_power),
		.thermal_load(thermal_load), .ramp_frequency(ramp_frequency),
		.control_method(control_method),
		.digital_monitor_pin(digital_monitor_pin),
		.voltage_monitor_channel(voltage_monitor_channel),
		.current_loop_monitor_channel(current_loop_monitor_channel),
		.analog_freq_source_en(analog_freq_source_en)
	);
	dmog_meter meter_i (
		.core_clk(core_clk), .digital_monitor_pin(digital_monitor_pin),
		.clear(meter_clear), .high_cnt(high_cnt), .edge_cnt(edge_cnt)
	);
	// Monitored quantity for a source code, torque masked outside vector
	function automatic int qval(input int c);
		case (c)
			0: return int'(out_freq);
			1: return int'(out_current);
			2: return (control_method inside {[3:5]}) ? int'(out_torque) : 0;
			4: return int'(out_voltage);
			5: return int'(in_power);
			6: return int'(thermal_load);
			default: return int'(ramp_frequency);
		endcase
	endfunction : qval
	// Full scale: max frequency 60.0 Hz, 200 % or 100 %
	function automatic int qfs(input int c);
		case (c)
			0, 7: return 600;
			1, 2, 5: return 2000;
			default: return 1000;
		endcase
	endfunction : qfs
	// Value over full scale times gain over 255, saturated at span
	function automatic int sc(input int v, input int g, input int f,
		input int span);
		int t;
		t = v * g * span / (f * 255);
		return (t > span) ? span : t;
	endfunction : sc
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd
	task automatic chk_val(input string n, input logic [15:0] e,
		input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s expected %0d seen %0d", n, e, g);
		end
	endtask : chk_val
	task automatic chk_reg(input logic [3:0] a, input logic [15:0] e);
		logic [15:0] d;
		rd(a, d);
		chk_val($sformatf("reg %0d", a), e, d);
	endtask : chk_reg
	task automatic chk_cnt(input string n, input int lo, input int hi,
		input logic [31:0] g);
		comparisons++;
		if ((g >= lo && g <= hi) !== 1'b1) begin
			error_cnt++;
			$display("BAD %s expected %0d..%0d seen %0d", n, lo, hi, g);
		end
	endtask : chk_cnt
	// Clear the meter, then let it watch the pin for w clocks
	task automatic watch(input int w);
		@(posedge core_clk);
		meter_clear <= 1'b1;
		@(posedge core_clk);
		meter_clear <= 1'b0;
		repeat (w) @(posedge core_clk);
		#1;
	endtask : watch
	task automatic stop_test();
		$display("checks %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : stop_test
	// Hang guard
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == LIMIT) begin
			error_cnt++;
			stop_test();
		end
	end
	// Main sequence
	initial begin
		int d;
		int v;
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk_val("current code", 16'd400, 16'(current_loop_monitor_channel));
		chk_reg(dmog_pkg::A_VGAIN, 16'd180);
		chk_reg(dmog_pkg::A_VOFS, 16'd0);
		chk_reg(dmog_pkg::A_CGAIN, 16'd80);
		chk_reg(dmog_pkg::A_COFS, 16'd0);
		chk_reg(dmog_pkg::A_DSEL, 16'd0);
		chk_reg(4'hf, 16'h0000);
		wr(dmog_pkg::A_VOFS, 16'h00ff);
		chk_reg(dmog_pkg::A_VOFS, 16'd100);
		wr(dmog_pkg::A_COFS, 16'h0fff);
		chk_reg(dmog_pkg::A_COFS, 16'd200);
		wr(dmog_pkg::A_VSEL, 16'h0002);
		wr(dmog_pkg::A_VSEL, 16'h0003);
		chk_reg(dmog_pkg::A_VSEL, 16'd2);
		wr(dmog_pkg::A_FSRC, 16'h0001);
		repeat (2) @(posedge core_clk);
		chk_val("freq source", 16'd1, 16'(analog_freq_source_en));
		wr(dmog_pkg::A_FSRC, 16'h0002);
		repeat (2) @(posedge core_clk);
		chk_val("freq source", 16'd0, 16'(analog_freq_source_en));
		$display("test registers done");
		// Analog channels, each source on both channels in turn
		wr(dmog_pkg::A_VGAIN, 16'd255);
		wr(dmog_pkg::A_CGAIN, 16'd128);
		wr(dmog_pkg::A_VOFS, 16'd10);
		wr(dmog_pkg::A_COFS, 16'd5); // 0.5 mA lifts every current code by 50
		for (int i = 0; i < 8; i++) begin
			if (i == 7) control_method <= 3'h4;
			wr(dmog_pkg::A_VSEL, 16'(codes[i % 7 == 0 && i > 0 ? 2 : i % 7]));
			wr(dmog_pkg::A_CSEL, 16'(codes[6 - (i % 7)]));
			repeat (3 * SC) @(posedge core_clk);
			d = (i == 7) ? 2 : codes[i];
			// Scaled value plus 1.0 V offset, clamped at 10.00 V
			v = sc(qval(d), 255, qfs(d), 1000) + 100;
			v = (v > 1000) ? 1000 : v;
			chk_val("volt code", 16'(v),
				16'(voltage_monitor_channel));
			chk_reg(dmog_pkg::A_VCODE, 16'(v));
			// 4 mA base, scaled value, 0.5 mA offset
			d = codes[6 - (i % 7)];
			v = 450 + sc(qval(d), 128, qfs(d), 1600);
			chk_val("curr code", 16'(v),
				16'(current_loop_monitor_channel));
			chk_reg(dmog_pkg::A_CCODE, 16'(v));
		end
		control_method <= 3'h0;
		$display("test analog done");
		// Pulse width per source with gain 200
		wr(dmog_pkg::A_DGAIN, 16'd200);
		for (int i = 0; i < 7; i++) begin
			wr(dmog_pkg::A_DSEL, 16'(codes[i]));
			repeat (512) @(posedge core_clk);
			d = sc(qval(codes[i]), 200, qfs(codes[i]), 256);
			chk_reg(dmog_pkg::A_DUTY, 16'(d));
			watch(1024);
			chk_cnt("high time", 4 * d, 4 * d, high_cnt);
		end
		wr(dmog_pkg::A_DGAIN, 16'd255);
		wr(dmog_pkg::A_DSEL, 16'd7);
		repeat (512) @(posedge core_clk);
		watch(1024);
		chk_cnt("saturated", 1024, 1024, high_cnt);
		wr(dmog_pkg::A_DGAIN, 16'd0);
		wr(dmog_pkg::A_CTRL, 16'h0001);
		watch(1024);
		chk_cnt("calibration", 1024, 1024, high_cnt);
		wr(dmog_pkg::A_CTRL, 16'h0000);
		$display("test pulse width done");
		// Pulse train for 400.0 Hz, about 4000 pulses per second, gain left at zero
		wr(dmog_pkg::A_MAXF, 16'hffff);
		chk_reg(dmog_pkg::A_MAXF, 16'd4000);
		out_freq <= 12'hfa0;
		wr(dmog_pkg::A_DSEL, 16'h0003);
		watch(40000);
		chk_cnt("pulse count", 3, 4, edge_cnt);
		chk_reg(dmog_pkg::A_STAT, 16'h0004);
		$display("test pulse train done");
		stop_test();
	end
endmodule : dmog_bench

// *** sim/dmog_meter.sv ***
// Panel meter model: counts pin high time and rising edges
`timescale 1ns/1ps
module dmog_meter (
	input wire logic core_clk,
	input wire logic digital_monitor_pin,
	input wire logic clear,
	output logic [31:0] high_cnt,
	output logic [31:0] edge_cnt
);
	logic pin_d = 1'b0; // Pin one clock ago
	// Integrate like a moving coil, count pulses like a counter input
	always_ff @(posedge core_clk) begin
		pin_d <= digital_monitor_pin;
		if (clear) begin
			high_cnt <= 32'h0;
			edge_cnt <= 32'h0;
		end else begin
			high_cnt <= high_cnt + 32'(digital_monitor_pin);
			edge_cnt <= edge_cnt + 32'(digital_monitor_pin & ~pin_d);
		end
	end
endmodule : dmog_meter
